// ---- fwp_regs.svh ----
`ifndef FWP_REGS_SVH
`define FWP_REGS_SVH

// Register byte offsets on the plain register port.
`define FWP_OFF_STATUS 8'h00
`define FWP_OFF_SECT 8'h04
`define FWP_OFF_BLANK 8'h08
`define FWP_OFF_REJECT 8'h0C

// Status word field positions.
`define FWP_SR_WEL 1
`define FWP_SR_BP_LO 2
`define FWP_SR_BP_HI 6
`define FWP_SR_SRP0 7
`define FWP_SR_SRP1 8
`define FWP_SR_CMP 14
`define FWP_SR_RESET 16'h0000

// Array geometry.
`define FWP_ARRAY_TOP 24'h1FFFFF
`define FWP_ARRAY_BYTES 25'h0200000
`define FWP_SECT_SHIFT 12
`define FWP_SECT_LAST 24'h000FFF
`define FWP_BLOCK_SHIFT 5'h0F
`define FWP_SMALL_SHIFT 5'h0B
`define FWP_BYTE_BITS 3'h0

`endif

// ---- fwp_pkg.sv ----
`default_nettype none
package fwp_pkg;

   typedef enum logic [3:0] {
      FWP_OP_NONE = 4'h0,
      FWP_OP_WRITE_PERMIT_CMD = 4'h1,
      FWP_OP_WRDI = 4'h2,
      FWP_OP_WRSR = 4'h3,
      FWP_OP_READ = 4'h4,
      FWP_OP_PROG = 4'h5,
      FWP_OP_ERASE = 4'h6,
      FWP_OP_CHIP = 4'h7,
      FWP_OP_DPD = 4'h8,
      FWP_OP_RDPD = 4'h9
   } fwp_op_e;

   typedef enum logic [1:0] {
      FWP_ST_STANDBY = 2'h0,
      FWP_ST_SELECTED = 2'h1,
      FWP_ST_DEEP_SEL = 2'h2,
      FWP_ST_DEEP = 2'h3
   } fwp_state_e;

endpackage

`default_nettype wire

// ---- fwp_range_dec.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fwp_regs.svh"

module fwp_range_dec
   import fwp_pkg::*;
(
   input wire logic [4:0] bp,
   input wire logic cmp,
   output logic prot_none,
   output logic [23:0] prot_lo,
   output logic [23:0] prot_hi
);

   logic [4:0] shift;
   logic [23:0] size_m1;
   logic sel_none;
   logic sel_all;

   always_comb
   begin
      sel_none = (bp[2:0] == 3'h0);
      sel_all = (bp[2:1] == 2'h3);
      if (!bp[4])
         shift = `FWP_BLOCK_SHIFT + {2'h0, bp[2:0]};
      else if (bp[2])
         shift = `FWP_BLOCK_SHIFT;
      else
         shift = `FWP_SMALL_SHIFT + {2'h0, bp[2:0]};
      size_m1 = (24'h000001 << shift) - 24'h000001;
      prot_none = 1'b0;
      prot_lo = 24'h000000;
      prot_hi = `FWP_ARRAY_TOP;
      if (!cmp)
      begin
         if (sel_none)
            prot_none = 1'b1;
         else if (sel_all)
            prot_none = 1'b0;
         else if (!bp[3])
            prot_lo = `FWP_ARRAY_TOP - size_m1;
         else
            prot_hi = size_m1;
      end
      else
      begin
         // The complement of a top or bottom region is one contiguous region.
         if (sel_none)
            prot_none = 1'b0;
         else if (sel_all)
            prot_none = 1'b1;
         else if (!bp[3])
            prot_hi = `FWP_ARRAY_TOP - size_m1 - 24'h000001;
         else
            prot_lo = size_m1 + 24'h000001;
      end
   end

endmodule

`default_nettype wire

// ---- fwp_frame.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fwp_regs.svh"

module fwp_frame
   import fwp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic select_n,
   input wire logic bit_strobe,
   output logic frame_end,
   output logic byte_ok
);

   typedef struct packed {
      logic sel_low;
      logic any;
      logic [2:0] cnt;
   } fwp_frame_s;

   fwp_frame_s q_r;
   fwp_frame_s q_nxt;

   always_comb
   begin
      q_nxt = q_r;
      q_nxt.sel_low = !select_n;
      if (select_n)
      begin
         q_nxt.any = 1'b0;
         q_nxt.cnt = 3'h0;
      end
      else if (bit_strobe)
      begin
         q_nxt.any = 1'b1;
         q_nxt.cnt = q_r.cnt + 3'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   assign frame_end = q_r.sel_low & select_n;
   assign byte_ok = q_r.any & (q_r.cnt == `FWP_BYTE_BITS);

endmodule

`default_nettype wire

// ---- fwp_guard.sv ----
// Behaviour
// - Plain codes protect top or bottom 64 KB multiples.
// - Small-region codes protect 4 to 32 KB.
// - Complement bit inverts the selected region exactly.
// - Touching protected memory drops the whole command.
// - Reads of protected regions pass, except in deep power-down.
// - Changes need the write latch set first.
// - Changing commands must end on byte boundary.
// - Low guard pin freezes BP and SRP bits; CMP still updates.
// - Deep power-down accepts only the release command.
// - Power-up resets the sequencer to standby.
// - Status word is all zero after reset.
// - Array starts fully erased, all ones.
`timescale 1ns/1ps
`default_nettype none
`include "fwp_regs.svh"

module fwp_guard
   import fwp_pkg::*;
#(
   parameter int SECTORS = 512
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic select_n,
   input wire logic bit_strobe,
   input wire logic write_guard_n,
   input wire fwp_op_e cmd_op,
   input wire logic [23:0] cmd_addr,
   input wire logic [23:0] cmd_len,
   input wire logic [15:0] cmd_data,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic exec_go,
   output fwp_op_e exec_op,
   output logic [23:0] exec_addr,
   output logic [23:0] exec_len,
   output logic cmd_reject,
   output logic deep_active
);

   typedef struct packed {
      fwp_state_e state;
      logic write_latch_flag;
      logic [4:0] bp;
      logic cmp;
      logic [1:0] srp;
      logic [SECTORS-1:0] blank;
      logic [8:0] sect_sel;
      logic [15:0] rej_cnt;
      logic [31:0] rdata;
      logic go;
      fwp_op_e op;
      logic [23:0] addr;
      logic [23:0] len;
      logic reject;
   } fwp_guard_s;

   fwp_guard_s q_r;
   fwp_guard_s q_nxt;

   logic frame_end;
   logic byte_ok;
   logic prot_none;
   logic [23:0] prot_lo;
   logic [23:0] prot_hi;
   logic deep;
   logic is_change;
   logic is_array;
   logic [24:0] t_lo;
   logic [24:0] t_hi;
   logic hit;
   logic [15:0] status;

   function automatic logic fwp_hits(input logic [24:0] lo, input logic [24:0] hi,
                                     input logic [23:0] plo, input logic [23:0] phi,
                                     input logic none);
      fwp_hits = !none && (lo <= {1'b0, phi}) && (hi >= {1'b0, plo});
   endfunction

   fwp_frame u_frame (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .select_n(select_n),
      .bit_strobe(bit_strobe),
      .frame_end(frame_end),
      .byte_ok(byte_ok)
   );

   fwp_range_dec u_range (
      .bp(q_r.bp),
      .cmp(q_r.cmp),
      .prot_none(prot_none),
      .prot_lo(prot_lo),
      .prot_hi(prot_hi)
   );

   always_comb
   begin
      status = `FWP_SR_RESET;
      status[`FWP_SR_WEL] = q_r.write_latch_flag;
      status[`FWP_SR_BP_HI:`FWP_SR_BP_LO] = q_r.bp;
      status[`FWP_SR_SRP0] = q_r.srp[0];
      status[`FWP_SR_SRP1] = q_r.srp[1];
      status[`FWP_SR_CMP] = q_r.cmp;
   end

   assign deep = (q_r.state == FWP_ST_DEEP) || (q_r.state == FWP_ST_DEEP_SEL);
   assign is_array = (cmd_op == FWP_OP_PROG) || (cmd_op == FWP_OP_ERASE) ||
                     (cmd_op == FWP_OP_CHIP);
   assign is_change = (cmd_op != FWP_OP_READ) && (cmd_op != FWP_OP_NONE);

   // A zero length still targets the addressed byte, and the carry bit keeps a range
   // that runs past the top of the address space from wrapping to a low address.
   always_comb
   begin
      if (cmd_op == FWP_OP_CHIP)
      begin
         t_lo = 25'h0000000;
         t_hi = `FWP_ARRAY_BYTES - 25'h0000001;
      end
      else
      begin
         t_lo = {1'b0, cmd_addr};
         t_hi = {1'b0, cmd_addr} + {1'b0, cmd_len} - ((cmd_len == 24'h000000) ? 25'h0000000
                                                                               : 25'h0000001);
      end
      hit = fwp_hits(t_lo, t_hi, prot_lo, prot_hi, prot_none);
   end

   always_comb
   begin
      logic [23:0] s_lo;
      s_lo = 24'h000000;
      q_nxt = q_r;
      q_nxt.go = 1'b0;
      q_nxt.reject = 1'b0;
      q_nxt.rdata = 32'h00000000;
      case (q_r.state)
         FWP_ST_STANDBY:
            if (!select_n)
               q_nxt.state = FWP_ST_SELECTED;
         FWP_ST_SELECTED:
            if (frame_end)
               q_nxt.state = FWP_ST_STANDBY;
         FWP_ST_DEEP:
            if (!select_n)
               q_nxt.state = FWP_ST_DEEP_SEL;
         FWP_ST_DEEP_SEL:
            if (frame_end)
               q_nxt.state = FWP_ST_DEEP;
         default:
            q_nxt.state = FWP_ST_STANDBY;
      endcase
      if (frame_end && cmd_op != FWP_OP_NONE)
      begin
         if (deep)
         begin
            if (cmd_op == FWP_OP_RDPD && byte_ok)
               q_nxt.state = FWP_ST_STANDBY;
            else
               q_nxt.reject = 1'b1;
         end
         else if (is_change && !byte_ok)
            q_nxt.reject = 1'b1;
         else
         begin
            case (cmd_op)
               FWP_OP_WRITE_PERMIT_CMD:
                  q_nxt.write_latch_flag = 1'b1;
               FWP_OP_WRDI:
                  q_nxt.write_latch_flag = 1'b0;
               FWP_OP_DPD:
                  q_nxt.state = FWP_ST_DEEP;
               FWP_OP_WRSR:
                  if (!q_r.write_latch_flag)
                     q_nxt.reject = 1'b1;
                  else
                  begin
                     q_nxt.write_latch_flag = 1'b0;
                     q_nxt.cmp = cmd_data[`FWP_SR_CMP];
                     if (write_guard_n)
                     begin
                        q_nxt.bp = cmd_data[`FWP_SR_BP_HI:`FWP_SR_BP_LO];
                        q_nxt.srp = {cmd_data[`FWP_SR_SRP1], cmd_data[`FWP_SR_SRP0]};
                     end
                  end
               FWP_OP_READ:
                  q_nxt.go = 1'b1;
               default:
                  if (!is_array || !q_r.write_latch_flag || hit)
                     q_nxt.reject = 1'b1;
                  else
                  begin
                     q_nxt.go = 1'b1;
                     q_nxt.write_latch_flag = 1'b0;
                     // The blank map is per sector, so a page erase marks its whole
                     // sector blank; it is a coarse view, not a byte image.
                     for (int i = 0; i < SECTORS; i++)
                     begin
                        s_lo = 24'(i) << `FWP_SECT_SHIFT;
                        if (fwp_hits(t_lo, t_hi, s_lo, s_lo + `FWP_SECT_LAST, 1'b0))
                           q_nxt.blank[i] = (cmd_op != FWP_OP_PROG);
                     end
                  end
            endcase
            if (q_nxt.go)
            begin
               q_nxt.op = cmd_op;
               q_nxt.addr = t_lo[23:0];
               q_nxt.len = cmd_len;
            end
         end
      end
      if (q_nxt.reject)
         q_nxt.rej_cnt = q_r.rej_cnt + 16'h0001;
      if (reg_wr && reg_addr == `FWP_OFF_SECT)
         q_nxt.sect_sel = reg_wdata[8:0];
      if (reg_wr && reg_addr == `FWP_OFF_REJECT)
         q_nxt.rej_cnt = 16'h0000;
      if (reg_rd)
      begin
         case (reg_addr)
            `FWP_OFF_STATUS:
               q_nxt.rdata = {16'h0000, status};
            `FWP_OFF_SECT:
               q_nxt.rdata = {23'h000000, q_r.sect_sel};
            `FWP_OFF_BLANK:
               q_nxt.rdata = {31'h00000000, q_r.blank[q_r.sect_sel]};
            `FWP_OFF_REJECT:
               q_nxt.rdata = {16'h0000, q_r.rej_cnt};
            default:
               q_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q_r <= '0;
         q_r.state <= FWP_ST_STANDBY;
         q_r.blank <= '1;
      end
      else
         q_r <= q_nxt;
   end

   assign reg_rdata = q_r.rdata;
   assign exec_go = q_r.go;
   assign exec_op = q_r.op;
   assign exec_addr = q_r.addr;
   assign exec_len = q_r.len;
   assign cmd_reject = q_r.reject;
   assign deep_active = deep;

   sequence fwp_write_permit_cmd_seq;
      frame_end && !deep && byte_ok && cmd_op == FWP_OP_WRITE_PERMIT_CMD;
   endsequence

   sequence fwp_latch_seq;
      q_r.write_latch_flag [*1];
   endsequence

   write_permit_cmd_sets_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fwp_write_permit_cmd_seq |=> fwp_latch_seq) else $error("write permit did not set latch");

   no_latch_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_end && !deep && is_array && !q_r.write_latch_flag |=> !exec_go && cmd_reject)
      else $error("array change ran without latch");

   prot_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_end && !deep && is_array && hit |=> !exec_go && $stable(q_r.write_latch_flag)
      && $stable(q_r.blank)) else $error("protected change was not dropped");

   read_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_end && !deep && cmd_op == FWP_OP_READ |=> exec_go)
      else $error("read was blocked");

   byte_check_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_end && !deep && is_change && !byte_ok |=> cmd_reject && !exec_go)
      else $error("partial byte command not rejected");

   guard_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !write_guard_n |=> $stable(q_r.bp) && $stable(q_r.srp))
      else $error("protect bits changed under guard pin");

   deep_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      deep && frame_end && cmd_op != FWP_OP_RDPD |=> deep_active && !exec_go)
      else $error("command accepted in deep power-down");

   top_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q_r.bp == 5'h01 && !q_r.cmp |-> !prot_none && prot_lo == 24'h1F0000
      && prot_hi == 24'h1FFFFF) else $error("upper 1/32 decode wrong");

   small_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q_r.bp == 5'h1A && !q_r.cmp |-> !prot_none && prot_lo == 24'h000000
      && prot_hi == 24'h001FFF) else $error("lower 8 KB decode wrong");

   all_none_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q_r.bp[2:1] == 2'h3 && !q_r.cmp |-> !prot_none && prot_lo == 24'h000000
      && prot_hi == 24'h1FFFFF) else $error("whole array decode wrong");

   cmp_inv_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q_r.bp == 5'h11 && q_r.cmp |-> !prot_none && prot_lo == 24'h000000
      && prot_hi == 24'h1FEFFF) else $error("complement decode wrong");

   reset_clean_a: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> q_r.state == FWP_ST_STANDBY && status == 16'h0000
      && q_r.blank == '1) else $error("reset state not clean");

endmodule

`default_nettype wire

// ---- fwp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module fwp_host_model
   import fwp_pkg::*;
(
   input wire logic ref_clk,
   output logic select_n,
   output logic bit_strobe,
   output fwp_op_e cmd_op,
   output logic [23:0] cmd_addr,
   output logic [23:0] cmd_len,
   output logic [15:0] cmd_data
);
   // Idle cycles between bit strobes; nonzero makes a slow host.
   int gap = 0;

   initial
   begin
      select_n = 1'h1;
      bit_strobe = 1'h0;
      cmd_op = FWP_OP_NONE;
      cmd_addr = 24'h000000;
      cmd_len = 24'h000000;
      cmd_data = 16'h0000;
   end

   task automatic frame(input fwp_op_e op, input logic [23:0] a, input logic [23:0] n,
                        input logic [15:0] d, input int nbits);
      @(posedge ref_clk);
      select_n <= 1'h0;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_len <= n;
      cmd_data <= d;
      for (int i = 0; i < nbits; i++)
      begin
         @(posedge ref_clk);
         bit_strobe <= 1'h1;
         repeat (gap)
         begin
            @(posedge ref_clk);
            bit_strobe <= 1'h0;
         end
      end
      @(posedge ref_clk);
      bit_strobe <= 1'h0;
      select_n <= 1'h1;
      repeat (2) @(posedge ref_clk);
      // Released address, length and data are inverted so a stale value cannot pass for a held one.
      cmd_op <= FWP_OP_NONE;
      cmd_addr <= ~a;
      cmd_len <= ~n;
      cmd_data <= ~d;
   endtask
endmodule

`default_nettype wire

// ---- flash_write_protect_guard_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end

module flash_write_protect_guard_bench
   import fwp_pkg::*;
;
   localparam logic [23:0] Z = 24'h000000;
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic write_guard_n = 1'h1;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic select_n, bit_strobe, exec_go, cmd_reject, deep_active;
   fwp_op_e cmd_op, exec_op;
   logic [23:0] cmd_addr, cmd_len, exec_addr, exec_len;
   logic [15:0] cmd_data;
   logic [31:0] reg_rdata;
   logic [7:0] go_cnt, rej_cnt;
   int failures = 0;
   int samples_checked = 0;

   always #20 ref_clk = ~ref_clk;

   fwp_host_model host (.ref_clk(ref_clk), .select_n(select_n), .bit_strobe(bit_strobe),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_data(cmd_data));

   fwp_guard dut (.ref_clk(ref_clk), .rst_n(rst_n), .select_n(select_n),
      .bit_strobe(bit_strobe), .write_guard_n(write_guard_n), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_data(cmd_data), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .exec_go(exec_go), .exec_op(exec_op), .exec_addr(exec_addr), .exec_len(exec_len),
      .cmd_reject(cmd_reject), .deep_active(deep_active));

   // Counting pulses keeps the checks independent of the exact answer cycle.
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         go_cnt <= 8'h00;
         rej_cnt <= 8'h00;
      end
      else
      begin
         go_cnt <= go_cnt + {7'h00, exec_go};
         rej_cnt <= rej_cnt + {7'h00, cmd_reject};
      end
   end

   task automatic results();
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask

   task automatic cmd(input fwp_op_e op, input logic [23:0] a, input logic [23:0] n,
                      input logic [15:0] d, input int nbits, input logic eg, input logic er);
      logic [7:0] g0;
      logic [7:0] r0;
      g0 = go_cnt;
      r0 = rej_cnt;
      host.frame(op, a, n, d, nbits);
      repeat (3) @(posedge ref_clk);
      `CHK(go_cnt - g0, {7'h00, eg})
      `CHK(rej_cnt - r0, {7'h00, er})
   endtask

   task automatic write_permit_cmd();
      cmd(FWP_OP_WRITE_PERMIT_CMD, Z, Z, 16'h0000, 8, 1'h0, 1'h0);
   endtask

   task automatic pcase(input logic [4:0] bp, input logic c, input fwp_op_e op,
                        input logic [23:0] a, input logic [23:0] n, input logic p);
      write_permit_cmd();
      cmd(FWP_OP_WRSR, Z, Z, {1'h0, c, 7'h00, bp, 2'h0}, 24, 1'h0, 1'h0);
      rd(8'h00, {17'h00000, c, 7'h00, bp, 2'h0});
      write_permit_cmd();
      cmd(op, a, n, 16'h0000, 32, !p, p);
      if (p)
         rd(8'h00, {17'h00000, c, 7'h00, bp, 2'h2});
      else
      begin
         `CHK(exec_op, op)
         `CHK(exec_addr, a)
         `CHK(exec_len, n)
      end
   endtask

   task automatic fresh();
      `CHK(deep_active, 1'h0)
      rd(8'h00, 32'h00000000);
      wr(8'h04, 32'h000001F0);
      rd(8'h04, 32'h000001F0);
      rd(8'h08, 32'h00000001);
      rd(8'h0C, 32'h00000000);
      rd(8'h10, 32'h00000000);
   endtask

   initial
   begin
      repeat (100000) @(posedge ref_clk);
      failures++;
      results();
   end

   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'h1;
      repeat (1750) @(posedge ref_clk);
      fresh();
      cmd(FWP_OP_PROG, Z, Z, 16'h0000, 32, 1'h0, 1'h1);
      write_permit_cmd();
      cmd(FWP_OP_WRDI, Z, Z, 16'h0000, 8, 1'h0, 1'h0);
      cmd(FWP_OP_PROG, Z, Z, 16'h0000, 32, 1'h0, 1'h1);
      rd(8'h0C, 32'h00000002);
      wr(8'h0C, 32'h00000000);
      rd(8'h0C, 32'h00000000);
      host.gap = 2;
      write_permit_cmd();
      cmd(FWP_OP_PROG, Z, Z, 16'h0000, 13, 1'h0, 1'h1);
      host.gap = 0;
      pcase(5'h01, 1'h0, FWP_OP_PROG, 24'h1F0000, 24'h000001, 1'h1);
      pcase(5'h01, 1'h0, FWP_OP_PROG, 24'h1EFFFF, 24'h000001, 1'h0);
      pcase(5'h09, 1'h0, FWP_OP_PROG, 24'h00FFFF, 24'h000001, 1'h1);
      pcase(5'h09, 1'h0, FWP_OP_PROG, 24'h010000, 24'h000001, 1'h0);
      pcase(5'h05, 1'h0, FWP_OP_PROG, 24'h100000, 24'h000001, 1'h1);
      pcase(5'h05, 1'h0, FWP_OP_PROG, 24'h0FFFFF, 24'h000001, 1'h0);
      pcase(5'h11, 1'h0, FWP_OP_PROG, 24'h1FF000, 24'h000001, 1'h1);
      pcase(5'h11, 1'h0, FWP_OP_PROG, 24'h1FEFFF, 24'h000001, 1'h0);
      pcase(5'h1D, 1'h0, FWP_OP_PROG, 24'h007FFF, 24'h000001, 1'h1);
      pcase(5'h1D, 1'h0, FWP_OP_PROG, 24'h008000, 24'h000001, 1'h0);
      pcase(5'h1A, 1'h0, FWP_OP_PROG, 24'h001FFF, 24'h000001, 1'h1);
      pcase(5'h1A, 1'h0, FWP_OP_PROG, 24'h002000, 24'h000001, 1'h0);
      pcase(5'h18, 1'h0, FWP_OP_CHIP, Z, Z, 1'h0);
      pcase(5'h06, 1'h0, FWP_OP_PROG, Z, 24'h000001, 1'h1);
      pcase(5'h01, 1'h1, FWP_OP_PROG, 24'h1EFFFF, 24'h000001, 1'h1);
      pcase(5'h01, 1'h1, FWP_OP_PROG, 24'h1F0000, 24'h000001, 1'h0);
      pcase(5'h19, 1'h1, FWP_OP_PROG, 24'h000FFF, 24'h000001, 1'h0);
      pcase(5'h19, 1'h1, FWP_OP_PROG, 24'h001000, 24'h000001, 1'h1);
      pcase(5'h11, 1'h1, FWP_OP_PROG, 24'h1FEFFF, 24'h000001, 1'h1);
      pcase(5'h11, 1'h1, FWP_OP_PROG, 24'h1FF000, 24'h000001, 1'h0);
      pcase(5'h00, 1'h1, FWP_OP_PROG, 24'h1FFFFF, 24'h000001, 1'h1);
      pcase(5'h0E, 1'h1, FWP_OP_CHIP, Z, Z, 1'h0);
      pcase(5'h01, 1'h0, FWP_OP_ERASE, 24'h1EF000, 24'h001000, 1'h0);
      pcase(5'h01, 1'h0, FWP_OP_ERASE, 24'h1EF000, 24'h011000, 1'h1);
      pcase(5'h01, 1'h0, FWP_OP_CHIP, Z, Z, 1'h1);
      cmd(FWP_OP_READ, 24'h1F0000, Z, 16'h0000, 20, 1'h1, 1'h0);
      `CHK(exec_op, FWP_OP_READ)
      `CHK(exec_addr, 24'h1F0000)
      @(posedge ref_clk);
      write_guard_n <= 1'h0;
      write_permit_cmd();
      cmd(FWP_OP_WRSR, Z, Z, 16'h41FC, 24, 1'h0, 1'h0);
      rd(8'h00, 32'h00004004);
      @(posedge ref_clk);
      write_guard_n <= 1'h1;
      write_permit_cmd();
      cmd(FWP_OP_WRSR, Z, Z, 16'h41FC, 24, 1'h0, 1'h0);
      rd(8'h00, 32'h000041FC);
      cmd(FWP_OP_DPD, Z, Z, 16'h0000, 8, 1'h0, 1'h0);
      `CHK(deep_active, 1'h1)
      cmd(FWP_OP_WRITE_PERMIT_CMD, Z, Z, 16'h0000, 8, 1'h0, 1'h1);
      cmd(FWP_OP_READ, Z, Z, 16'h0000, 32, 1'h0, 1'h1);
      cmd(FWP_OP_RDPD, Z, Z, 16'h0000, 8, 1'h0, 1'h0);
      `CHK(deep_active, 1'h0)
      cmd(FWP_OP_DPD, Z, Z, 16'h0000, 8, 1'h0, 1'h0);
      rst_n <= 1'h0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      fresh();
      results();
   end
endmodule

`default_nettype wire
